// ---- verilog/bbc_decoder.sv ----
// branch, bit manipulation and control opcode decoder and executer
`timescale 1ns/1ps
`default_nettype none

module bbc_decoder import bbc_pkg::*; #(
  parameter int MC_DIV = 4
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      prog_data,
  input  wire logic            flag_load,
  input  wire logic            flag_zero_in,
  input  wire logic            flag_carry_in,
  input  wire logic            ext_call,
  input  wire logic [PC_W-1:0] ext_call_target,
  output logic      [PC_W-1:0] prog_addr,
  output logic                 instr_done,
  output logic                 unimp_op,
  output logic                 call_ack,
  output logic                 zero_flag,
  output logic                 carry_flag,
  output logic      [7:0]      acc_val,
  output logic      [7:0]      xindex_val,
  output logic      [7:0]      yindex_val
);

  initial begin
    if (MC_DIV < 2 || MC_DIV > 256) begin
      $error("MC_DIV must lie in 2..256");
    end
  end

  localparam logic [7:0] DIV_LAST = 8'(MC_DIV - 1);

  typedef struct packed {
    bbc_state_t                      st;
    logic [PC_W-1:0]                 pc;
    logic [PC_W-1:0]                 prog_addr;
    logic [7:0]                      op;
    logic [7:0]                      opr1;
    logic [7:0]                      opr2;
    logic [2:0]                      cyc;
    logic [2:0]                      tot;
    logic                            zero;
    logic                            carry;
    logic [STK_DEPTH-1:0][PC_W-1:0]  stk_pc;
    logic [STK_DEPTH-1:0]            stk_z;
    logic [STK_DEPTH-1:0]            stk_c;
    logic [1:0]                      sp;
    logic [7:0]                      div;
    logic                            tick;
    logic                            done;
    logic                            unimp;
    logic                            ack;
    logic                            we;
    logic [7:0]                      wa;
    logic [7:0]                      wd;
    logic [7:0]                      acc;
    logic [7:0]                      xr;
    logic [7:0]                      yr;
  } bbc_core_t;

  bbc_core_t s_ff;
  bbc_core_t nxt_s;
  logic [7:0] ram [256];
  logic       fin;

  function automatic bbc_class_t op_class(input logic [7:0] op);
    if (!op[BR_GROUP_BIT])                                   return CL_BR;
    if ((op & GROUP_MASK) == OPC_TEST_BIT_BRANCH_IF_ZERO)    return CL_BTB;
    if ((op & GROUP_MASK) == OPC_BIT_FORCE_ZERO)             return CL_BSC;
    if (op == OPC_ACC_TO_XINDEX || op == OPC_ACC_TO_YINDEX ||
        op == OPC_XINDEX_TO_ACC || op == OPC_YINDEX_TO_ACC)  return CL_XFER;
    if (op == OPC_SUB_RETURN || op == OPC_INTERRUPT_RETURN)  return CL_RET;
    return CL_OTHER;
  endfunction

  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    case (op_class(op))
      CL_BR:   return CYC_BR;
      CL_BTB:  return CYC_BTB;
      CL_BSC:  return CYC_BSC;
      CL_XFER: return CYC_XFER;
      CL_RET:  return CYC_RET;
      default: return CYC_OTHER;
    endcase
  endfunction

  function automatic logic [1:0] op_bytes(input logic [7:0] op);
    case (op_class(op))
      CL_BTB:  return LEN_THREE;
      CL_BSC:  return LEN_TWO;
      default: return LEN_ONE;
    endcase
  endfunction

  function automatic logic [PC_W-1:0] sext5(input logic [4:0] v);
    return {{(PC_W-5){v[OFS5_MSB]}}, v};
  endfunction

  function automatic logic [PC_W-1:0] sext8(input logic [7:0] v);
    return {{(PC_W-8){v[7]}}, v};
  endfunction

  function automatic logic br_taken(input logic [1:0] cond, input logic z, input logic c);
    case (cond)
      COND_ZERO_CLEAR:  return !z;
      COND_ZERO_SET:    return z;
      COND_CARRY_CLEAR: return !c; // also the higher-same alias
      default:          return c;  // carry set, also the lower alias
    endcase
  endfunction

  assign fin = (s_ff.st == ST_EXEC) && s_ff.tick && (3'(s_ff.cyc + 3'h1) == s_ff.tot);

  always_comb begin
    logic [7:0]      rd;
    logic [PC_W-1:0] pc_inc;
    rd         = ram[s_ff.opr1];
    pc_inc     = PC_W'(s_ff.pc + 1'b1);
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.unimp = 1'b0;
    nxt_s.ack  = 1'b0;
    nxt_s.we   = 1'b0;
    nxt_s.tick = (s_ff.div == DIV_LAST);
    nxt_s.div  = (s_ff.div == DIV_LAST) ? 8'h00 : 8'(s_ff.div + 8'h01);
    // the mirrors follow the RAM write so the outputs stay flop-driven
    if (s_ff.we && s_ff.wa == ADDR_ACC) begin
      nxt_s.acc = s_ff.wd;
    end
    if (s_ff.we && s_ff.wa == ADDR_XINDEX) begin
      nxt_s.xr = s_ff.wd;
    end
    if (s_ff.we && s_ff.wa == ADDR_YINDEX) begin
      nxt_s.yr = s_ff.wd;
    end
    case (s_ff.st)
      ST_FETCH: begin
        if (s_ff.tick) begin
          nxt_s.op        = prog_data;
          nxt_s.pc        = pc_inc;
          nxt_s.prog_addr = pc_inc;
          nxt_s.cyc       = 3'h1;
          nxt_s.tot       = op_cycles(prog_data);
          nxt_s.st        = ST_EXEC;
        end else begin
          // side requests only between ticks so they never race an opcode fetch
          if (flag_load) begin
            nxt_s.zero  = flag_zero_in;
            nxt_s.carry = flag_carry_in;
          end
          if (ext_call && s_ff.sp != 2'(STK_DEPTH)) begin
            nxt_s.stk_pc[STK_IDX_W'(s_ff.sp)] = s_ff.pc;
            nxt_s.stk_z[STK_IDX_W'(s_ff.sp)]  = flag_load ? flag_zero_in : s_ff.zero;
            nxt_s.stk_c[STK_IDX_W'(s_ff.sp)]  = flag_load ? flag_carry_in : s_ff.carry;
            nxt_s.sp        = 2'(s_ff.sp + 2'h1);
            nxt_s.pc        = ext_call_target;
            nxt_s.prog_addr = ext_call_target;
            nxt_s.ack       = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        if (s_ff.tick) begin
          nxt_s.cyc = 3'(s_ff.cyc + 3'h1);
          if (s_ff.cyc == 3'h1 && op_bytes(s_ff.op) != LEN_ONE) begin
            nxt_s.opr1      = prog_data;
            nxt_s.pc        = pc_inc;
            nxt_s.prog_addr = pc_inc;
          end
          if (s_ff.cyc == 3'h2 && op_bytes(s_ff.op) == LEN_THREE) begin
            nxt_s.opr2      = prog_data;
            nxt_s.pc        = pc_inc;
            nxt_s.prog_addr = pc_inc;
          end
        end
        if (fin) begin
          nxt_s.st   = ST_FETCH;
          nxt_s.done = 1'b1;
          case (op_class(s_ff.op))
            CL_BR: begin
              // zero offset on the zero-set branch is the no-operation form
              if (br_taken(s_ff.op[COND_MSB:COND_LSB], s_ff.zero, s_ff.carry)) begin
                nxt_s.pc = PC_W'(s_ff.pc + sext5(s_ff.op[OFS5_MSB:0]));
              end
            end
            CL_BTB: begin
              nxt_s.carry = rd[s_ff.op[2:0]];
              if (rd[s_ff.op[2:0]] == s_ff.op[POL_BIT]) begin
                nxt_s.pc = PC_W'(s_ff.pc + sext8(s_ff.opr2));
              end
            end
            CL_BSC: begin
              nxt_s.we = 1'b1;
              nxt_s.wa = s_ff.opr1;
              nxt_s.wd = rd;
              nxt_s.wd[s_ff.op[2:0]] = s_ff.op[POL_BIT];
            end
            CL_XFER: begin
              nxt_s.we = 1'b1;
              case (s_ff.op)
                OPC_ACC_TO_XINDEX: begin
                  nxt_s.wa = ADDR_XINDEX;
                  nxt_s.wd = ram[ADDR_ACC];
                end
                OPC_ACC_TO_YINDEX: begin
                  nxt_s.wa = ADDR_YINDEX;
                  nxt_s.wd = ram[ADDR_ACC];
                end
                OPC_XINDEX_TO_ACC: begin
                  nxt_s.wa   = ADDR_ACC;
                  nxt_s.wd   = ram[ADDR_XINDEX];
                  nxt_s.zero = (ram[ADDR_XINDEX] == 8'h00);
                end
                default: begin
                  nxt_s.wa   = ADDR_ACC;
                  nxt_s.wd   = ram[ADDR_YINDEX];
                  nxt_s.zero = (ram[ADDR_YINDEX] == 8'h00);
                end
              endcase
            end
            CL_RET: begin
              // an empty stack simply falls through to the next byte
              if (s_ff.sp != 2'h0) begin
                nxt_s.pc = s_ff.stk_pc[STK_IDX_W'(s_ff.sp - 2'h1)];
                nxt_s.sp = 2'(s_ff.sp - 2'h1);
                if (s_ff.op == OPC_INTERRUPT_RETURN) begin
                  nxt_s.zero  = s_ff.stk_z[STK_IDX_W'(s_ff.sp - 2'h1)];
                  nxt_s.carry = s_ff.stk_c[STK_IDX_W'(s_ff.sp - 2'h1)];
                end
              end
            end
            default: begin
              nxt_s.unimp = 1'b1;
            end
          endcase
          nxt_s.prog_addr = nxt_s.pc;
        end
      end
      default: begin
        nxt_s.st = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // RAM holds no reset so it maps onto plain storage
  always_ff @(posedge ref_clk) begin
    if (s_ff.we) begin
      ram[s_ff.wa] <= s_ff.wd;
    end
  end

  assign prog_addr  = s_ff.prog_addr;
  assign instr_done = s_ff.done;
  assign unimp_op   = s_ff.unimp;
  assign call_ack   = s_ff.ack;
  assign zero_flag  = s_ff.zero;
  assign carry_flag = s_ff.carry;
  assign acc_val    = s_ff.acc;
  assign xindex_val = s_ff.xr;
  assign yindex_val = s_ff.yr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence q_br_fin;
    fin && op_class(s_ff.op) == CL_BR;
  endsequence

  property p_br_target;
    q_br_fin and br_taken(s_ff.op[COND_MSB:COND_LSB], s_ff.zero, s_ff.carry)
      |=> s_ff.pc == PC_W'($past(s_ff.pc) + sext5($past(s_ff.op[OFS5_MSB:0])));
  endproperty
  a_br_target: assert property (p_br_target) else $error("branch target wrong");

  property p_br_not_taken;
    q_br_fin and !br_taken(s_ff.op[COND_MSB:COND_LSB], s_ff.zero, s_ff.carry) |=> $stable(s_ff.pc);
  endproperty
  a_br_not_taken: assert property (p_br_not_taken) else $error("untaken branch moved pc");

  property p_br_one_byte;
    s_ff.st == ST_FETCH && s_ff.tick && !prog_data[BR_GROUP_BIT]
      |=> s_ff.tot == CYC_BR && s_ff.pc == PC_W'($past(s_ff.pc) + 1'b1);
  endproperty
  a_br_one_byte: assert property (p_br_one_byte) else $error("branch length or cycles wrong");

  property p_br_flags;
    q_br_fin |=> $stable(s_ff.zero) && $stable(s_ff.carry);
  endproperty
  a_br_flags: assert property (p_br_flags) else $error("branch changed flags");

  property p_nop_alias;
    fin && s_ff.op == OPC_NO_OPERATION_ALIAS |=> s_ff.pc == $past(s_ff.pc) && instr_done;
  endproperty
  a_nop_alias: assert property (p_nop_alias) else $error("no-operation did not land on next byte");

  property p_btb_carry;
    fin && op_class(s_ff.op) == CL_BTB |=> carry_flag == $past(ram[s_ff.opr1][s_ff.op[2:0]]);
  endproperty
  a_btb_carry: assert property (p_btb_carry) else $error("tested bit not copied to carry");

  property p_bsc_write;
    fin && op_class(s_ff.op) == CL_BSC
      |=> s_ff.we ##1 ram[$past(s_ff.opr1, 2)][$past(s_ff.op[2:0], 2)] == $past(s_ff.op[POL_BIT], 2);
  endproperty
  a_bsc_write: assert property (p_bsc_write) else $error("bit force result wrong");

  property p_acc_sign;
    fin && s_ff.op == (OPC_BIT_FORCE_ONE | 8'(SIGN_BIT)) && s_ff.opr1 == ADDR_ACC |=> ##2 acc_val[SIGN_BIT];
  endproperty
  a_acc_sign: assert property (p_acc_sign) else $error("accumulator not forced negative");

  property p_xfer_x;
    fin && s_ff.op == OPC_ACC_TO_XINDEX |=> ##2 xindex_val == $past(ram[ADDR_ACC], 3);
  endproperty
  a_xfer_x: assert property (p_xfer_x) else $error("acc to x transfer wrong");

  property p_ret_pop;
    fin && op_class(s_ff.op) == CL_RET && s_ff.sp != 2'h0
      |=> s_ff.sp == 2'($past(s_ff.sp) - 2'h1) && prog_addr == s_ff.pc;
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not pop");

endmodule

`default_nettype wire

// ---- verilog/bbc_pkg.sv ----
// shared constants and types for the branch, bit and control opcode decoder
package bbc_pkg;

  localparam int PC_W       = 12;
  localparam int STK_DEPTH  = 2;
  localparam int STK_IDX_W  = 1;

  // relative branch group: op[7]==0, op[6:5] picks the condition, op[4:0] is the offset
  localparam int          BR_GROUP_BIT = 7;
  localparam int          COND_MSB     = 6;
  localparam int          COND_LSB     = 5;
  localparam int          OFS5_MSB     = 4;
  localparam logic [1:0]  COND_ZERO_CLEAR  = 2'h0;
  localparam logic [1:0]  COND_ZERO_SET    = 2'h1;
  localparam logic [1:0]  COND_CARRY_CLEAR = 2'h2;
  localparam logic [1:0]  COND_CARRY_SET   = 2'h3;
  localparam logic [1:0]  COND_HIGHER_SAME_ALIAS = COND_CARRY_CLEAR;
  localparam logic [1:0]  COND_LOWER_ALIAS       = COND_CARRY_SET;

  // bit groups: base opcode plus bit number in op[2:0], op[3] is the polarity
  localparam logic [7:0]  OPC_TEST_BIT_BRANCH_IF_ZERO = 8'hC0;
  localparam logic [7:0]  OPC_TEST_BIT_BRANCH_IF_ONE  = 8'hC8;
  localparam logic [7:0]  OPC_BIT_FORCE_ZERO          = 8'hD0;
  localparam logic [7:0]  OPC_BIT_FORCE_ONE           = 8'hD8;
  localparam int          POL_BIT      = 3;
  localparam logic [7:0]  BASE_MASK    = 8'hF8;
  localparam logic [7:0]  GROUP_MASK   = 8'hF0;
  localparam logic [2:0]  SIGN_BIT     = 3'h7;

  // control group
  localparam logic [7:0]  OPC_ACC_TO_XINDEX  = 8'hBC;
  localparam logic [7:0]  OPC_ACC_TO_YINDEX  = 8'hBD;
  localparam logic [7:0]  OPC_XINDEX_TO_ACC  = 8'hAC;
  localparam logic [7:0]  OPC_YINDEX_TO_ACC  = 8'hAD;
  localparam logic [7:0]  OPC_SUB_RETURN     = 8'hB3;
  localparam logic [7:0]  OPC_INTERRUPT_RETURN = 8'hB2;
  localparam logic [7:0]  OPC_NO_OPERATION_ALIAS = 8'h20;

  // register locations in data RAM
  localparam logic [7:0]  ADDR_ACC    = 8'hFF;
  localparam logic [7:0]  ADDR_XINDEX = 8'h80;
  localparam logic [7:0]  ADDR_YINDEX = 8'h81;

  // machine cycles and lengths
  localparam logic [2:0]  CYC_BR    = 3'h2;
  localparam logic [2:0]  CYC_BTB   = 3'h5;
  localparam logic [2:0]  CYC_BSC   = 3'h4;
  localparam logic [2:0]  CYC_XFER  = 3'h4;
  localparam logic [2:0]  CYC_RET   = 3'h2;
  localparam logic [2:0]  CYC_OTHER = 3'h2;
  localparam logic [1:0]  LEN_ONE   = 2'h1;
  localparam logic [1:0]  LEN_TWO   = 2'h2;
  localparam logic [1:0]  LEN_THREE = 2'h3;

  typedef enum logic {ST_FETCH, ST_EXEC} bbc_state_t;
  typedef enum logic [2:0] {CL_BR, CL_BTB, CL_BSC, CL_XFER, CL_RET, CL_OTHER} bbc_class_t;

endpackage

// ---- sim/bbc_prog_mem.sv ----
// program memory model that feeds opcode bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module bbc_prog_mem import bbc_pkg::*; (
  input  wire logic            ref_clk,
  input  wire logic [PC_W-1:0] prog_addr,
  input  wire logic [1:0]      lat,
  output logic      [7:0]      prog_data
);
  logic [7:0]      mem [0:(1<<PC_W)-1];
  logic [PC_W-1:0] last_addr_ff = '0;
  logic [1:0]      age_ff = 2'h3;

  always_ff @(posedge ref_clk) begin
    last_addr_ff <= prog_addr;
    if (prog_addr != last_addr_ff) begin
      age_ff <= 2'h0;
    end else if (age_ff != 2'h3) begin
      age_ff <= age_ff + 2'h1;
    end
  end

  // a slow read shows the inverted byte until its access time runs out, so a too-early sample shows up
  assign prog_data = (lat == 2'h0 || (prog_addr == last_addr_ff && age_ff >= lat)) ? mem[prog_addr] : ~mem[prog_addr];
endmodule
`default_nettype wire

// ---- sim/test_branch_bit_control_opcode_decoder.sv ----
// self-checking bench for the branch, bit and control opcode decoder
`timescale 1ns/1ps
`default_nettype none
module test_branch_bit_control_opcode_decoder import bbc_pkg::*;;
  localparam int MCD = 4;
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic            flag_load = 1'b0;
  logic            fz = 1'b0;
  logic            fc = 1'b0;
  logic            ext_call = 1'b0;
  logic [PC_W-1:0] tgt = '0;
  logic [1:0]      lat = 2'h0;
  logic [7:0]      prog_data, acc_val, xindex_val, yindex_val, op, ofs;
  logic [PC_W-1:0] prog_addr, pa;
  logic            instr_done, unimp_op, call_ack, zero_flag, carry_flag, zf, cf, ack_seen, z, c, b;
  logic            u0, u1;
  logic [7:0]      r [3];
  logic [7:0]      mir [3];
  logic [7:0]      xop [4] = '{8'hBC, 8'hAD, 8'hBD, 8'hAC};
  int              xdst [4] = '{1, 0, 2, 0};
  int              xsrc [4] = '{0, 2, 0, 1};
  int              miscompares = 0, tests_run = 0, seed = 54, cyc = 0, gap, i, j;

  bbc_decoder #(.MC_DIV(MCD)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .prog_data(prog_data), .flag_load(flag_load),
    .flag_zero_in(fz), .flag_carry_in(fc), .ext_call(ext_call), .ext_call_target(tgt),
    .prog_addr(prog_addr), .instr_done(instr_done), .unimp_op(unimp_op), .call_ack(call_ack),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .acc_val(acc_val),
    .xindex_val(xindex_val), .yindex_val(yindex_val));

  bbc_prog_mem i_mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .lat(lat), .prog_data(prog_data));

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic taken(input logic [7:0] o, input logic zz, input logic cc);
    case (o[6:5])
      2'h0: return !zz;
      2'h1: return zz;
      2'h2: return !cc;
      default: return cc;
    endcase
  endfunction

  function automatic logic [PC_W-1:0] rel(input logic [PC_W-1:0] base, input logic [7:0] d);
    return base + {{(PC_W-8){d[7]}}, d};
  endfunction

  function automatic logic [7:0] adr(input int k);
    return (k == 0) ? 8'hFF : (k == 1) ? 8'h80 : 8'h81;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (exp !== got) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // program sits at 1..3 behind a filler at 0, so the gap between the two done pulses is the instruction's run time in clock cycles
  task automatic run(input int n, input logic call);
    int k;
    int t;
    z = 1'($random(seed)) | (i_mem.mem[1] == 8'h20); // the no-op case always runs with zero set
    c = 1'($random(seed));
    lat <= 2'({$random(seed)} % 3);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    flag_load <= 1'b1;
    fz <= z;
    fc <= c;
    ext_call <= call;
    @(posedge ref_clk);
    flag_load <= 1'b0;
    ext_call <= 1'b0;
    @(negedge ref_clk);
    ack_seen = call_ack;
    for (k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(negedge ref_clk);
        t++;
      end while (instr_done !== 1'b1 && t < 100);
      gap = t;
      if (k == 0) u0 = unimp_op;
    end
    u1 = unimp_op;
    pa = prog_addr;
    zf = zero_flag;
    cf = carry_flag;
    repeat (3) @(negedge ref_clk);
    mir = '{acc_val, xindex_val, yindex_val};
    for (k = 1; k < 4; k++) i_mem.mem[k] = 8'h90;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    for (i = 0; i < 4096; i++) i_mem.mem[i] = 8'h90;
    repeat (20) @(posedge ref_clk);
    for (i = 0; i < 40; i++) begin
      op = (i == 0) ? 8'h20 : 8'($random(seed)) & 8'h7F;
      i_mem.mem[1] = op;
      run(2, 1'b0);
      check("br_pc", taken(op, z, c) ? rel(12'h2, {{3{op[4]}}, op[4:0]}) : 12'h2, pa);
      check("br_gap", 2 * MCD, gap);
      check("br_zc", {z, c}, {zf, cf});
      check("unimp", 16'h2, {u0, u1});
    end
    $display("relative branch test done");
    for (i = 0; i < 24; i++) begin
      op = 8'($random(seed));
      r[i / 8][i % 8] = op[0];
      i_mem.mem[1] = (op[0] ? 8'hD8 : 8'hD0) | 8'(i % 8);
      i_mem.mem[2] = adr(i / 8);
      run(2, 1'b0);
      check("bf_pc", 12'h3, pa);
      check("bf_gap", 4 * MCD, gap);
      check("bf_zc", {z, c}, {zf, cf});
      if (i % 8 == 7) check("bf_reg", r[i / 8], mir[i / 8]);
    end
    $display("bit force test done");
    for (i = 0; i < 24; i++) begin
      op = 8'($random(seed));
      // the first three aim at the sign bit of each register
      if (i < 3) op[5:0] = {2'(i), op[3], 3'h7};
      j = op[5:4] % 3;
      b = r[j][op[2:0]];
      ofs = 8'($random(seed));
      i_mem.mem[1] = 8'hC0 | (op & 8'h0F);
      i_mem.mem[2] = adr(j);
      i_mem.mem[3] = ofs;
      run(2, 1'b0);
      check("btb_pc", (b == op[3]) ? rel(12'h4, ofs) : 12'h4, pa);
      check("btb_gap", 5 * MCD, gap);
      check("btb_zc", {z, b}, {zf, cf});
    end
    $display("bit test branch test done");
    for (i = 0; i < 4; i++) begin
      r[xdst[i]] = r[xsrc[i]];
      i_mem.mem[1] = xop[i];
      run(2, 1'b0);
      check("xfer_pc", 12'h2, pa);
      check("xfer_gap", 4 * MCD, gap);
      check("xfer_val", r[xdst[i]], mir[xdst[i]]);
    end
    $display("transfer test done");
    tgt <= 12'h100;
    for (i = 0; i < 4; i++) begin
      op = i[0] ? 8'hB2 : 8'hB3;
      i_mem.mem[12'h101] = op;
      i_mem.mem[1] = op;
      run(2, i[1]);
      check("ret_ack", i[1], ack_seen);
      check("ret_pc", i[1] ? 12'h0 : 12'h2, pa);
      check("ret_gap", 2 * MCD, gap);
    end
    $display("return test done");
    end_of_test();
  end
endmodule
`default_nettype wire
